// [vtd_pkg.sv]
// Purpose: shared constants for the voltage trip detector
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes: control register fields follow the documented layout
package vtd_pkg;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [3:0] VTD_OFS_CTRL = 4'h0;
    localparam logic [3:0] VTD_OFS_FLAG = 4'h4;
    localparam logic [3:0] VTD_OFS_IEN = 4'h8;
    localparam logic [3:0] VTD_OFS_ICLR = 4'hC;
    // ==========================================================
    // control register fields
    localparam int VTD_DIR_BIT = 7;
    localparam int VTD_BGST_BIT = 6;
    localparam int VTD_REFST_BIT = 5;
    localparam int VTD_EN_BIT = 4;
    localparam int VTD_LVL_MSB = 3;
    localparam logic [7:0] VTD_CTRL_RESET = 8'h05;
    localparam logic [3:0] VTD_LVL_EXT = 4'hF;
    // ==========================================================
    // flag, enable and interrupt fields
    localparam int VTD_TRIP_BIT = 2;
    localparam int VTD_GIE_BIT = 7;
    localparam logic [7:0] VTD_IEN_RESET = 8'h00;
    // ==========================================================
    // settle timing: figure in ns, count derived from a 40 ns clock
    localparam int VTD_CLK_NS = 40;
    localparam int VTD_SETTLE_NS = 1000;
    localparam int VTD_SETTLE_CYC = (VTD_SETTLE_NS + VTD_CLK_NS - 1) / VTD_CLK_NS;
    localparam logic [7:0] VTD_SETTLE_CNT = 8'(VTD_SETTLE_CYC);
    typedef enum logic [1:0] {VTD_OFF, VTD_SETTLE, VTD_RUN} vtd_state_t;
endpackage

// [vtd_sync.sv]
// Purpose: two flip-flop synchroniser for one asynchronous level
// Assumes: single clock clk_i, synchronous active high reset
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module vtd_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // level in and out
    input wire logic async_i,
    output logic sync_o
);
    logic meta;
    // ==========================================================
    // two stage capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule

// [vtd_top.sv]
// Purpose: control and event logic of a supply voltage trip detector
// Assumes: analog comparator, divider and shared reference are outside
// Notes: registers on classic wishbone, one aligned word each
`timescale 1ns/1ps
module vtd_top
    import vtd_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // analog side, asynchronous levels
    input wire logic cmp_above_i,
    input wire logic ref_ready_i,
    input wire logic bandgap_ok_i,
    input wire logic other_ref_user_i,
    // analog side controls
    output logic detector_power_o,
    output logic [3:0] tap_select_o,
    output logic use_external_trip_o,
    output logic ref_request_o,
    // device status
    input wire logic sleep_i,
    output logic wake_o,
    output logic irq_o,
    output logic vector_o
);
    logic [7:0] ctrl;
    logic trip_flag;
    logic [7:0] ien;
    vtd_state_t state;
    vtd_state_t next_state;
    logic [7:0] settle;
    logic cmp_s;
    logic ref_s;
    logic bg_s;
    logic oth_s;
    wire [3:0] async_in = {other_ref_user_i, bandgap_ok_i, ref_ready_i, cmp_above_i};
    wire [3:0] sync_out;

    // ==========================================================
    // synchronisers
    // sync analog levels
    for (genvar i = 0; i < 4; i++) begin : g_sync
        vtd_sync u_sync (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .async_i(async_in[i]),
            .sync_o(sync_out[i])
        );
    end
    // synchronised levels by name
    assign cmp_s = sync_out[0];
    assign ref_s = sync_out[1];
    assign bg_s = sync_out[2];
    assign oth_s = sync_out[3];

    // ==========================================================
    // bus decode
    // address compare, shared by write decode and read mux
    function automatic logic adr_hit(input logic [3:0] adr, input logic [3:0] ofs);
        return adr == ofs;
    endfunction
    wire bus_req = cyc_i && stb_i && !ack_o;
    wire wr = bus_req && we_i && sel_i[0];
    wire wr_ctrl = wr && adr_hit(adr_i, VTD_OFS_CTRL);
    wire wr_flag = wr && adr_hit(adr_i, VTD_OFS_FLAG);
    wire wr_ien = wr && adr_hit(adr_i, VTD_OFS_IEN);
    wire wr_iclr = wr && adr_hit(adr_i, VTD_OFS_ICLR);

    // ==========================================================
    // detector control
    wire enabled = ctrl[VTD_EN_BIT];
    wire dir_rise = ctrl[VTD_DIR_BIT];
    wire [3:0] level = ctrl[VTD_LVL_MSB:0];
    wire ref_stable = (state == VTD_RUN);
    wire crossed = dir_rise ? cmp_s : !cmp_s;
    wire trip_evt = ref_stable && crossed;
    // reference lost when the synchronised ready level is low
    wire ref_lost = !ref_s;

    // ==========================================================
    // settle state machine
    // wait on analog ready, not a clock count alone
    always_comb begin
        next_state = state;
        case (state)
            VTD_OFF: begin
                if (enabled) begin
                    next_state = VTD_SETTLE;
                end
            end
            VTD_SETTLE: begin
                if (!enabled) begin
                    next_state = VTD_OFF;
                end else if (ref_s && settle == 8'h00) begin
                    next_state = VTD_RUN;
                end
            end
            VTD_RUN: begin
                if (!enabled) begin
                    next_state = VTD_OFF;
                end else if (ref_lost) begin
                    next_state = VTD_SETTLE;
                end
            end
            default: begin
                next_state = VTD_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= VTD_OFF;
            settle <= 8'h00;
        end else begin
            state <= next_state;
            if (state != VTD_SETTLE) begin
                settle <= VTD_SETTLE_CNT;
            end else if (settle != 8'h00) begin
                settle <= settle - 8'h01;
            end
        end
    end

    // ==========================================================
    // registers
    // reset values
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= VTD_CTRL_RESET;
            ien <= VTD_IEN_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl[VTD_DIR_BIT] <= dat_i[VTD_DIR_BIT];
                ctrl[VTD_EN_BIT:0] <= dat_i[VTD_EN_BIT:0];
            end
            ctrl[VTD_BGST_BIT] <= bg_s;
            ctrl[VTD_REFST_BIT] <= (next_state == VTD_RUN);
            if (wr_ien) begin
                ien <= dat_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trip_flag <= 1'b0;
        end else if (trip_evt) begin
            trip_flag <= 1'b1;
        end else if (wr_iclr && dat_i[VTD_TRIP_BIT]) begin
            trip_flag <= 1'b0;
        end else if (wr_flag && !dat_i[VTD_TRIP_BIT]) begin
            trip_flag <= 1'b0;
        end
    end

    // ==========================================================
    // read mux
    wire [7:0] rd_byte = adr_hit(adr_i, VTD_OFS_CTRL) ? ctrl :
        adr_hit(adr_i, VTD_OFS_FLAG) ? {5'h00, trip_flag, 2'h0} :
        adr_hit(adr_i, VTD_OFS_IEN) ? ien : 8'h00;

    // ==========================================================
    // interrupt and wake
    // both enables needed for irq and vector, none for wake
    wire irq_next = trip_flag && ien[VTD_TRIP_BIT] && ien[VTD_GIE_BIT];
    wire wake_next = sleep_i && trip_flag;
    wire vector_next = trip_flag && ien[VTD_TRIP_BIT] && ien[VTD_GIE_BIT] && !sleep_i;

    // outputs from flip-flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            detector_power_o <= 1'b0;
            tap_select_o <= 4'h0;
            use_external_trip_o <= 1'b0;
            ref_request_o <= 1'b0;
            wake_o <= 1'b0;
            irq_o <= 1'b0;
            vector_o <= 1'b0;
        end else begin
            ack_o <= bus_req;
            dat_o <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            detector_power_o <= enabled;
            tap_select_o <= level;
            use_external_trip_o <= enabled && (level == VTD_LVL_EXT);
            ref_request_o <= enabled || oth_s;
            wake_o <= wake_next;
            irq_o <= irq_next;
            vector_o <= vector_next;
        end
    end

    // ==========================================================
    // assertions
    // band gap bit follows synchronised input
    property p_bg;
        @(posedge clk_i) disable iff (rst_i) ctrl[VTD_BGST_BIT] == $past(bg_s);
    endproperty
    a_bg: assert property (p_bg) else $error("band gap bit wrong");

    property p_nostable;
        @(posedge clk_i) disable iff (rst_i) !enabled |=> !ctrl[VTD_REFST_BIT];
    endproperty
    a_nostable: assert property (p_nostable) else $error("stable while off");

    property p_flag_gate;
        @(posedge clk_i) disable iff (rst_i) !trip_flag && !ref_stable |=> !trip_flag;
    endproperty
    a_flag_gate: assert property (p_flag_gate) else $error("flag before stable");

    property p_sticky;
        @(posedge clk_i) disable iff (rst_i) trip_flag && !wr_flag && !wr_iclr |=> trip_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");

    property p_set;
        @(posedge clk_i) disable iff (rst_i) trip_evt |=> trip_flag;
    endproperty
    a_set: assert property (p_set) else $error("trip not flagged");

    property p_irq;
        @(posedge clk_i) disable iff (rst_i) irq_o |-> $past(trip_flag) && $past(ien[VTD_GIE_BIT]);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without enables");

    property p_ext;
        @(posedge clk_i) disable iff (rst_i) enabled && level == VTD_LVL_EXT |=> use_external_trip_o;
    endproperty
    a_ext: assert property (p_ext) else $error("external input not chosen");

    sequence s_enable;
        !enabled ##1 enabled;
    endsequence
    property p_settle;
        @(posedge clk_i) disable iff (rst_i) s_enable |-> !ctrl[VTD_REFST_BIT] [*8];
    endproperty
    a_settle: assert property (p_settle) else $error("stable too early");

    property p_wake;
        @(posedge clk_i) disable iff (rst_i) sleep_i && trip_flag |=> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake request");

    sequence s_ack_pulse;
        ack_o ##1 !ack_o;
    endsequence
    property p_ack;
        @(posedge clk_i) disable iff (rst_i) bus_req |=> s_ack_pulse;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not a single pulse");

    property p_power;
        @(posedge clk_i) disable iff (rst_i) !rst_i |=> detector_power_o == $past(enabled);
    endproperty
    a_power: assert property (p_power) else $error("power does not follow enable");

    property p_tap;
        @(posedge clk_i) disable iff (rst_i) !rst_i |=> tap_select_o == $past(level);
    endproperty
    a_tap: assert property (p_tap) else $error("tap does not follow level");

    property p_ext_off;
        @(posedge clk_i) disable iff (rst_i) !enabled |=> !use_external_trip_o;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("external input while off");

    property p_stable_ref;
        @(posedge clk_i) disable iff (rst_i) ctrl[VTD_REFST_BIT] |-> $past(ref_s);
    endproperty
    a_stable_ref: assert property (p_stable_ref) else $error("stable without ready");

    property p_resettle;
        @(posedge clk_i) disable iff (rst_i)
            ref_stable && ref_lost |=> !ctrl[VTD_REFST_BIT] && !ref_stable;
    endproperty
    a_resettle: assert property (p_resettle) else $error("stable after ref loss");

    property p_refreq;
        @(posedge clk_i) disable iff (rst_i) enabled || oth_s |=> ref_request_o;
    endproperty
    a_refreq: assert property (p_refreq) else $error("reference not requested");

    sequence s_sleep_trip;
        sleep_i && trip_evt ##1 sleep_i;
    endsequence
    property p_sleep_wake;
        @(posedge clk_i) disable iff (rst_i) s_sleep_trip |-> trip_flag ##1 wake_o;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep trip lost");

    property p_vector;
        @(posedge clk_i) disable iff (rst_i) vector_o |-> $past(ien[VTD_GIE_BIT]) && !$past(sleep_i);
    endproperty
    a_vector: assert property (p_vector) else $error("vector without global enable");

    property p_reset;
        @(posedge clk_i) rst_i |=> ctrl == VTD_CTRL_RESET && ien == VTD_IEN_RESET
            && !detector_power_o;
    endproperty
    a_reset: assert property (p_reset) else $error("reset values wrong");

    property p_irq_on;
        @(posedge clk_i) disable iff (rst_i)
            trip_flag && ien[VTD_TRIP_BIT] && ien[VTD_GIE_BIT] |=> irq_o;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq missing");

    property p_clear;
        @(posedge clk_i) disable iff (rst_i)
            wr_iclr && dat_i[VTD_TRIP_BIT] && !trip_evt |=> !trip_flag;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");
endmodule

// [tb.sv]
// Purpose: self-checking bench for the voltage trip detector
// Assumes: wishbone answers one cycle after a request, 25 cycle settle
// Notes: analog levels are driven by the bench at clock edges
`timescale 1ns/1ps
module tb;
import vtd_pkg::*;
// ==========================================================
// stimulus and observed signals
logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
logic [31:0] dat_i = 32'h0, dat_o, q;
logic ack_o, detector_power_o, use_external_trip_o, ref_request_o, wake_o, irq_o, vector_o;
logic cmp_above_i = 1, ref_ready_i = 0, bandgap_ok_i = 0, other_ref_user_i = 0, sleep_i = 0;
logic [3:0] tap_select_o;
int n_errors = 0, tests_run = 0;
vtd_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .cmp_above_i(cmp_above_i), .ref_ready_i(ref_ready_i), .bandgap_ok_i(bandgap_ok_i),
    .other_ref_user_i(other_ref_user_i), .detector_power_o(detector_power_o),
    .tap_select_o(tap_select_o), .use_external_trip_o(use_external_trip_o),
    .ref_request_o(ref_request_o), .sleep_i(sleep_i), .wake_o(wake_o), .irq_o(irq_o),
    .vector_o(vector_o));
// clock of 40 ns period
always #20 clk_i = ~clk_i;
// ==========================================================
// shared helpers
task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
endtask
task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
        n_errors++;
        $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
endtask
// one classic wishbone cycle, held until ack is sampled
task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= we;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
        @(posedge clk_i);
        n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    we_i <= 0;
    if (n >= 50) chk(1'b0, 1'b1, "ack");
endtask
task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 8'h00);
    chk(q, exp, what);
endtask
task automatic tally_and_finish;
    if (n_errors == 0 && tests_run > 0) begin
        $display("*** PASS ***");
    end else begin
        $display("*** FAIL ***");
    end
    $finish;
endtask
// ==========================================================
// scenarios
task automatic t_reset;
    rd(VTD_OFS_CTRL, 32'h05, "ctrl reset");
    rd(VTD_OFS_IEN, 32'h00, "ien reset");
    rd(VTD_OFS_ICLR, 32'h00, "clear reads zero");
    chk(detector_power_o, 1'b0, "power reset");
    bandgap_ok_i <= 1;
    tick(6);
    rd(VTD_OFS_CTRL, 32'h45, "bandgap bit");
endtask
task automatic t_settle;
    wb(1'b1, VTD_OFS_CTRL, 8'h03);
    chk(detector_power_o, 1'b0, "power off");
    wb(1'b1, VTD_OFS_CTRL, 8'h13);
    rd(VTD_OFS_CTRL, 32'h53, "not yet stable");
    chk(detector_power_o, 1'b1, "power on");
    chk(tap_select_o, 4'h3, "tap");
    cmp_above_i <= 0;
    tick(5);
    cmp_above_i <= 1;
    ref_ready_i <= 1;
    tick(40);
    rd(VTD_OFS_CTRL, 32'h73, "stable");
    rd(VTD_OFS_FLAG, 32'h00, "no early trip");
endtask
task automatic t_trip_fall;
    wb(1'b1, VTD_OFS_IEN, 8'h84);
    cmp_above_i <= 0;
    tick(6);
    rd(VTD_OFS_FLAG, 32'h04, "fall trip");
    chk(irq_o, 1'b1, "irq both enables");
    chk(vector_o, 1'b1, "vector awake");
    cmp_above_i <= 1;
    tick(6);
    rd(VTD_OFS_FLAG, 32'h04, "flag sticky");
    wb(1'b1, VTD_OFS_IEN, 8'h04);
    tick(3);
    chk(irq_o, 1'b0, "irq no global");
    wb(1'b1, VTD_OFS_ICLR, 8'h04);
    tick(3);
    rd(VTD_OFS_FLAG, 32'h00, "flag cleared");
endtask
task automatic t_ext_sleep;
    wb(1'b1, VTD_OFS_CTRL, 8'h03);
    wb(1'b1, VTD_OFS_CTRL, 8'h8F);
    cmp_above_i <= 0;
    wb(1'b1, VTD_OFS_CTRL, 8'h9F);
    tick(1);
    chk(use_external_trip_o, 1'b1, "external input");
    tick(40);
    rd(VTD_OFS_FLAG, 32'h00, "rise not yet");
    sleep_i <= 1;
    cmp_above_i <= 1;
    tick(6);
    chk(wake_o, 1'b1, "wake");
    chk(vector_o, 1'b0, "no vector");
    sleep_i <= 0;
    cmp_above_i <= 0;
    tick(6);
    wb(1'b1, VTD_OFS_FLAG, 8'h00);
    tick(3);
    rd(VTD_OFS_FLAG, 32'h00, "flag write zero");
endtask
task automatic t_resettle;
    ref_ready_i <= 0;
    tick(6);
    rd(VTD_OFS_CTRL, 32'hDF, "lost stable");
    cmp_above_i <= 1;
    tick(6);
    rd(VTD_OFS_FLAG, 32'h00, "no trip unstable");
    cmp_above_i <= 0;
    wb(1'b1, VTD_OFS_CTRL, 8'h8F);
    other_ref_user_i <= 1;
    tick(5);
    chk(ref_request_o, 1'b1, "shared request");
    other_ref_user_i <= 0;
    tick(5);
    chk(ref_request_o, 1'b0, "request off");
    sel_i <= 4'h0;
    wb(1'b1, VTD_OFS_CTRL, 8'h93);
    sel_i <= 4'hF;
    rd(VTD_OFS_CTRL, 32'hCF, "lane 0 masked");
endtask
task automatic t_midreset;
    wb(1'b1, VTD_OFS_CTRL, 8'h93);
    rst_i <= 1;
    tick(2);
    rst_i <= 0;
    tick(4);
    rd(VTD_OFS_CTRL, 32'h45, "ctrl after reset");
    chk(detector_power_o, 1'b0, "power after reset");
endtask
// ==========================================================
// main sequence and watchdog
initial begin
    tick(8);
    rst_i <= 0;
    t_reset;
    t_settle;
    t_trip_fall;
    t_ext_sleep;
    t_resettle;
    t_midreset;
    tally_and_finish;
end
initial begin
    #(40 * 5000);
    n_errors++;
    tally_and_finish;
end
endmodule
